// ===== logic/ep0_control_status.sv
// endpoint0 control/status register and its serial engine hooks
`timescale 1ns/1ps
module ep0_control_status
  import ep0_csr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // serial interface engine events, one-cycle pulses on clk_in
  input  wire logic       rx_packet_loaded_in,
  input  wire logic       tx_packet_sent_in,
  input  wire logic       tx_overwritten_in,
  input  wire logic       transfer_ended_in,
  input  wire logic       status_stage_done_in,
  input  wire logic       stall_sent_in,
  input  wire logic       in_token_in,
  input  wire logic       out_token_in,
  // handshake choice for the engine and state to it
  output handshake_t      handshake_out,
  output logic            handshake_valid_out,
  output logic            tx_packet_loaded_out,
  output logic            send_stall_out,
  output logic            irq_out
);
  logic [7:0] csr;
  logic [7:0] next_csr;
  logic [7:0] next_rdata;
  handshake_t next_handshake;
  logic       next_hs_valid;
  logic [NUM_EVENTS-1:0] irq_events;
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_enable;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic csr_wr;
  assign csr_wr = wr_in && hit(addr_in, ADDR_CSR);

  always_comb begin
    next_csr = csr;
    if (csr_wr) begin
      // firmware-owned bits; hardware may only add a clear afterwards
      next_csr[BIT_SEND_STALL] = csr[BIT_SEND_STALL] | wdata_in[BIT_SEND_STALL];
      next_csr[BIT_LAST_DATA]  = csr[BIT_LAST_DATA] | wdata_in[BIT_LAST_DATA];
      next_csr[BIT_TX_LOADED]  = csr[BIT_TX_LOADED] | wdata_in[BIT_TX_LOADED];
      // software may only clear sent-stall, never set it
      next_csr[BIT_STALL_SENT] = csr[BIT_STALL_SENT] & wdata_in[BIT_STALL_SENT];
      if (wdata_in[BIT_SVC_SETUP_END])
        next_csr[BIT_SETUP_END] = 1'b0;
      if (wdata_in[BIT_SVC_OUT]) begin
        next_csr[BIT_RX_WAITING] = 1'b0;
      end
    end
    if (tx_packet_sent_in || tx_overwritten_in)
      next_csr[BIT_TX_LOADED] = 1'b0;
    if (tx_packet_sent_in || status_stage_done_in || transfer_ended_in)
      next_csr[BIT_LAST_DATA] = 1'b0;
    // hardware sets win over the same-cycle software clears
    if (transfer_ended_in && !csr[BIT_LAST_DATA])
      next_csr[BIT_SETUP_END] = 1'b1;
    if (rx_packet_loaded_in)
      next_csr[BIT_RX_WAITING] = 1'b1;
    if (stall_sent_in) begin
      next_csr[BIT_STALL_SENT] = 1'b1;
      next_csr[BIT_SEND_STALL] = 1'b0;
    end
    next_csr[BIT_SVC_SETUP_END] = 1'b0;
    next_csr[BIT_SVC_OUT]       = 1'b0;
  end

  always_comb begin
    next_rdata = CSR_RESET;
    if (rd_in) begin
      if (hit(addr_in, ADDR_CSR))
        next_rdata = csr;
      else if (hit(addr_in, ADDR_IRQ_STATUS))
        next_rdata = {{(8 - NUM_EVENTS){1'b0}}, irq_status};
      else if (hit(addr_in, ADDR_IRQ_ENABLE))
        next_rdata = {{(8 - NUM_EVENTS){1'b0}}, irq_enable};
    end
  end

  // handshake answer for the token seen this cycle
  always_comb begin
    next_handshake = HS_NONE;
    next_hs_valid  = in_token_in || out_token_in;
    // answer only a token, so the choice stands for one cycle like its valid
    if (!next_hs_valid)
      next_handshake = HS_NONE;
    else if (csr[BIT_SEND_STALL])
      next_handshake = HS_STALL;
    else if (out_token_in && csr[BIT_LAST_DATA])
      next_handshake = HS_STALL;
    else if (in_token_in && csr[BIT_LAST_DATA] && !csr[BIT_TX_LOADED])
      next_handshake = HS_STALL;
    else if (in_token_in && !csr[BIT_TX_LOADED])
      next_handshake = HS_NAK;
  end

  always_comb begin
    irq_events = IRQ_RESET;
    irq_events[EV_RX_PACKET]   = rx_packet_loaded_in;
    irq_events[EV_TX_DONE]     = tx_packet_sent_in || tx_overwritten_in;
    irq_events[EV_STALL]       = stall_sent_in;
    irq_events[EV_SETUP_END]   = transfer_ended_in && !csr[BIT_LAST_DATA];
    irq_events[EV_STATUS_DONE] = status_stage_done_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      csr                  <= CSR_RESET;
      rdata_out            <= CSR_RESET;
      handshake_out        <= HS_NONE;
      handshake_valid_out  <= 1'b0;
      tx_packet_loaded_out <= 1'b0;
      send_stall_out       <= 1'b0;
    end else begin
      csr                  <= next_csr;
      rdata_out            <= next_rdata;
      handshake_out        <= next_handshake;
      handshake_valid_out  <= next_hs_valid;
      tx_packet_loaded_out <= next_csr[BIT_TX_LOADED];
      send_stall_out       <= next_csr[BIT_SEND_STALL];
    end
  end

  // irq output is registered inside the collector
  irq_collect u_irq (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .event_in     (irq_events),
    .clear_wr_in  (wr_in && hit(addr_in, ADDR_IRQ_CLEAR)),
    .enable_wr_in (wr_in && hit(addr_in, ADDR_IRQ_ENABLE)),
    .wdata_in     (wdata_in[NUM_EVENTS-1:0]),
    .status_out   (irq_status),
    .enable_out   (irq_enable),
    .irq_out      (irq_out)
  );
endmodule : ep0_control_status

// ===== logic/ep0_csr_pkg.sv
// constants for the endpoint0 control/status block
// Summary of operation
// - control/status register is 8 bits at address 0x11, all zero at reset
// - writing one to bit 7 clears the setup-end flag
// - bits 7 and 6 always read as zero
// - writing one to bit 6 clears the out-packet-ready flag
// - out-packet-ready is read-only; only the bit 6 write clears it
// - setup-end flag (bit 4) sets when a transfer ends before data-end
// - firmware sets data-end after last received packet; hardware clears it
// - sent-stall (bit 2) sets after a stall handshake goes out
// - packet sent clears in-packet-ready and raises an interrupt
// - setup or out packet overwriting the transmit packet does the same
// - received packet sets out-packet-ready and raises an interrupt
// - an in token is answered with nak while in-packet-ready, data-end and send-stall are all zero
// - an out packet after data-end is answered with a stall
package ep0_csr_pkg;
  localparam logic [7:0] ADDR_CSR        = 8'h11;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h41;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h42;
  localparam logic [7:0] CSR_RESET       = 8'h00;
  localparam int BIT_SVC_SETUP_END = 7;
  localparam int BIT_SVC_OUT       = 6;
  localparam int BIT_SEND_STALL    = 5;
  localparam int BIT_SETUP_END     = 4;
  localparam int BIT_LAST_DATA     = 3;
  localparam int BIT_STALL_SENT    = 2;
  localparam int BIT_TX_LOADED     = 1;
  localparam int BIT_RX_WAITING    = 0;
  // interrupt status bit positions
  localparam int NUM_EVENTS        = 5;
  localparam int EV_RX_PACKET      = 0;
  localparam int EV_TX_DONE        = 1;
  localparam int EV_STALL          = 2;
  localparam int EV_SETUP_END      = 3;
  localparam int EV_STATUS_DONE    = 4;
  localparam logic [NUM_EVENTS-1:0] IRQ_RESET = 5'h00;
  typedef enum logic [1:0] {
    HS_NONE,
    HS_NAK,
    HS_STALL
  } handshake_t;
endpackage : ep0_csr_pkg

// ===== logic/irq_collect.sv
// sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
module irq_collect
  import ep0_csr_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [NUM_EVENTS-1:0] event_in,
  input  wire logic                  clear_wr_in,
  input  wire logic                  enable_wr_in,
  input  wire logic [NUM_EVENTS-1:0] wdata_in,
  output logic      [NUM_EVENTS-1:0] status_out,
  output logic      [NUM_EVENTS-1:0] enable_out,
  output logic                       irq_out
);
  logic [NUM_EVENTS-1:0] next_status;
  logic [NUM_EVENTS-1:0] next_enable;
  logic                  next_irq;

  always_comb begin
    next_enable = enable_wr_in ? wdata_in : enable_out;
    // set wins over a clear in the same cycle
    next_status = (status_out & ~(clear_wr_in ? wdata_in : IRQ_RESET)) | event_in;
    next_irq    = |(next_status & next_enable);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out <= IRQ_RESET;
      enable_out <= IRQ_RESET;
      irq_out    <= 1'b0;
    end else begin
      status_out <= next_status;
      enable_out <= next_enable;
      irq_out    <= next_irq;
    end
  end
endmodule : irq_collect

// ===== sim/ep0_control_status_assertions.sv
// port assertions for the endpoint0 control/status block
`timescale 1ns/1ps
module ep0_control_status_assertions
  import ep0_csr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       in_token_in,
  input wire logic       stall_sent_in,
  input wire logic       tx_packet_sent_in,
  input wire handshake_t handshake_out,
  input wire logic       handshake_valid_out,
  input wire logic       tx_packet_loaded_out,
  input wire logic       send_stall_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_read_data_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_serviced_bits_zero: assert property (rdata_out[7:6] == 2'b00)
    else $error("serviced bits read nonzero");
  a_token_gets_answer: assert property (in_token_in |=> handshake_valid_out)
    else $error("no handshake after token");
  a_empty_not_sent: assert property (in_token_in && !tx_packet_loaded_out && !send_stall_out
    |=> handshake_out != HS_NONE)
    else $error("empty endpoint answered with data");
  a_forced_stall: assert property (in_token_in && send_stall_out |=> handshake_out == HS_STALL)
    else $error("forced stall not sent");
  a_stall_req_clear: assert property (stall_sent_in && !wr_in |-> ##[1:2] !send_stall_out)
    else $error("send stall kept after stall");
  a_tx_loaded_clear: assert property (tx_packet_sent_in && !wr_in
    |-> ##[1:2] !tx_packet_loaded_out)
    else $error("tx loaded kept after send");
  a_tx_set_cause: assert property ($rose(tx_packet_loaded_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("tx loaded rose without write");
  a_stall_set_cause: assert property ($rose(send_stall_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("send stall rose without write");
  cover property (in_token_in && send_stall_out);
  cover property (stall_sent_in);
  cover property (tx_packet_sent_in && tx_packet_loaded_out);
endmodule : ep0_control_status_assertions

bind ep0_control_status ep0_control_status_assertions i_chk (.clk_in, .rstn_in, .wr_in,
  .rd_in, .rdata_out, .in_token_in, .stall_sent_in, .tx_packet_sent_in, .handshake_out,
  .handshake_valid_out, .tx_packet_loaded_out, .send_stall_out);

// ===== sim/ep0_control_status_bench.sv
// self-checking bench for the endpoint0 control/status block
`timescale 1ns/1ps
module ep0_control_status_bench;
  import ep0_csr_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, ev;
  handshake_t hs;
  logic hv, txl, ss, irq;
  logic [7:0] exp_csr, rnd_ev, rnd_wd;
  logic [NUM_EVENTS-1:0] exp_irq;
  int miscompares = 0, n_tests = 0, seed = 63;
  always #2.5 clk_in = ~clk_in;
  usb_host_model i_host (.clk_in(clk_in), .ev_out(ev));
  ep0_control_status i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rx_packet_loaded_in(ev[0]), .tx_packet_sent_in(ev[1]), .tx_overwritten_in(ev[2]),
    .transfer_ended_in(ev[3]), .status_stage_done_in(ev[4]), .stall_sent_in(ev[5]),
    .in_token_in(ev[6]), .out_token_in(ev[7]), .handshake_out(hs),
    .handshake_valid_out(hv), .tx_packet_loaded_out(txl), .send_stall_out(ss),
    .irq_out(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_in) wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_in) rd_in <= 1'b0;
    #1 chk(rdata_out, exp, "rdata");
  endtask : rd
  // token then handshake one cycle later
  task automatic tok(input logic [7:0] m, input handshake_t exp);
    i_host.pulse(m);
    #1 chk({6'h00, hs}, {6'h00, exp}, "handshake");
    chk({7'h00, hv}, 8'h01, "handshake valid");
  endtask : tok
  // expected register after one engine pulse, from the bit rules
  function automatic logic [7:0] exp_ev(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] r;
    r = c;
    if (e[1] || e[2]) r[BIT_TX_LOADED] = 1'b0;
    if (e[1] || e[3] || e[4]) r[BIT_LAST_DATA] = 1'b0;
    if (e[3] && !c[BIT_LAST_DATA]) r[BIT_SETUP_END] = 1'b1;
    if (e[0]) r[BIT_RX_WAITING] = 1'b1;
    if (e[5]) begin
      r[BIT_STALL_SENT] = 1'b1;
      r[BIT_SEND_STALL] = 1'b0;
    end
    return r;
  endfunction : exp_ev
  // expected register after a software write
  function automatic logic [7:0] exp_wr(input logic [7:0] c, input logic [7:0] w);
    logic [7:0] r;
    r = c | (w & 8'h2A);
    r[BIT_STALL_SENT] = c[BIT_STALL_SENT] & w[BIT_STALL_SENT];
    if (w[BIT_SVC_SETUP_END]) r[BIT_SETUP_END] = 1'b0;
    if (w[BIT_SVC_OUT]) r[BIT_RX_WAITING] = 1'b0;
    return r;
  endfunction : exp_wr
  // interrupt status bits that one engine pulse sets
  function automatic logic [NUM_EVENTS-1:0] exp_irq_ev(input logic [7:0] c,
                                                       input logic [7:0] e);
    return {e[4], e[3] && !c[BIT_LAST_DATA], e[5], e[1] || e[2], e[0]};
  endfunction : exp_irq_ev
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    #20000 miscompares++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(ADDR_CSR, CSR_RESET);
    rd(8'h20, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h1F);
    rd(ADDR_IRQ_ENABLE, 8'h1F);
    i_host.pulse(8'h01);
    rd(ADDR_CSR, 8'h01);
    chk({7'h00, irq}, 8'h01, "irq");
    wr(ADDR_CSR, 8'(seed) & 8'h94);
    repeat (4) wr(ADDR_CSR, 8'($random(seed)) & 8'h94);
    rd(ADDR_CSR, 8'h01);
    wr(ADDR_CSR, 8'h40);
    rd(ADDR_CSR, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_CLEAR, 8'h1F);
    rd(ADDR_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq");
    wr(ADDR_CSR, 8'h02);
    tok(8'h40, HS_NONE);
    i_host.pulse(8'h02);
    rd(ADDR_CSR, 8'h00);
    tok(8'h40, HS_NAK);
    wr(ADDR_CSR, 8'h02);
    i_host.pulse(8'h04);
    rd(ADDR_CSR, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    #1 chk({7'h00, irq}, 8'h00, "irq masked");
    wr(ADDR_CSR, 8'h20);
    tok(8'h40, HS_STALL);
    i_host.pulse(8'h20);
    rd(ADDR_CSR, 8'h04);
    wr(ADDR_CSR, 8'h04);
    rd(ADDR_CSR, 8'h04);
    wr(ADDR_CSR, 8'h00);
    i_host.pulse(8'h08);
    rd(ADDR_CSR, 8'h10);
    wr(ADDR_CSR, 8'h80);
    rd(ADDR_CSR, 8'h00);
    wr(ADDR_CSR, 8'h08);
    tok(8'h40, HS_STALL);
    tok(8'h80, HS_STALL);
    wr(ADDR_CSR, 8'h0A);
    i_host.pulse(8'h02);
    rd(ADDR_CSR, 8'h00);
    tok(8'h80, HS_NONE);
    // random engine traffic and writes against the bit rules
    wr(ADDR_IRQ_CLEAR, 8'h1F);
    exp_csr = CSR_RESET;
    exp_irq = 5'h00;
    repeat (16) begin
      rnd_ev = 8'($random(seed));
      rnd_wd = 8'($random(seed));
      i_host.pulse(rnd_ev);
      exp_irq = exp_irq | exp_irq_ev(exp_csr, rnd_ev);
      exp_csr = exp_ev(exp_csr, rnd_ev);
      wr(ADDR_CSR, rnd_wd);
      exp_csr = exp_wr(exp_csr, rnd_wd);
      rd(ADDR_CSR, exp_csr);
      chk({7'h00, txl}, {7'h00, exp_csr[BIT_TX_LOADED]}, "tx loaded out");
      chk({7'h00, ss}, {7'h00, exp_csr[BIT_SEND_STALL]}, "send stall out");
    end
    rd(ADDR_IRQ_STATUS, {3'h0, exp_irq});
    wr(ADDR_IRQ_ENABLE, 8'h1F);
    #1 chk({7'h00, irq}, {7'h00, |exp_irq}, "irq enabled");
    close_out();
  end
endmodule : ep0_control_status_bench

// ===== sim/usb_host_model.sv
// far side model: host traffic seen as engine event pulses
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       clk_in,
  output logic      [7:0] ev_out
);
  initial ev_out = 8'h00;
  // one pulse per call; pulses never overlap, but one pulse may carry several events at once
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_in) ev_out <= m;
    @(posedge clk_in) ev_out <= 8'h00;
  endtask : pulse
endmodule : usb_host_model
